/* File: verilog/ulm_consts.vh */
`ifndef ULM_CONSTS_VH
`define ULM_CONSTS_VH

// setup/hysteresis register fields
`define ULM_SHR_SETUP_HI 7
`define ULM_SHR_SETUP_LO 4
`define ULM_SHR_TURN_HI 3
`define ULM_SHR_TURN_LO 0

// special function register bits
`define ULM_SFR_ADDR_TX 7
`define ULM_SFR_MDROP 6
`define ULM_SFR_IRDA11 3

// enhanced feature register bits
`define ULM_EFR_SPCHAR 5
`define ULM_EFR_ENH 4

// line control parity field and forced-0 code
`define ULM_LCR_PAR_HI 5
`define ULM_LCR_PAR_LO 3
`define ULM_LCR_FORCE0 3'h7

// modem control, irq enable, fifo control bits
`define ULM_MCR_IRDA 6
`define ULM_MCR_LOOP 4
`define ULM_IER_SLEEP 4
`define ULM_FCR_WAKE 3

// oversampling and infrared pulse widths, in 16x ticks
`define ULM_TICKS_PER_BIT 5'h10
`define ULM_IR10_TICKS 4'h3
`define ULM_IR11_TICKS 4'h4

// reset values
`define ULM_RST_RXON 1'b0
`define ULM_RST_ADDRPEND 1'b0

`endif

/* File: verilog/ulm_irda.v */
`timescale 1ns/1ps
`default_nettype none
`include "ulm_consts.vh"

module ulm_irda (
   // clock and reset
   input wire clk,
   input wire nrst,
   // timing from the baud generator
   input wire tick16,
   input wire bit_start,
   // mode
   input wire ir_en,
   input wire ir_fast,
   // serial data
   input wire tx_bit,
   input wire rx_line,
   output reg ir_tx,
   output reg rx_bit
);

   reg [3:0] pulse_cnt;
   reg [4:0] hold_cnt;
   reg rx_line_d;

   // encoder: high pulse per zero bit, counted in 16x ticks
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pulse_cnt <= 4'h0;
         ir_tx <= 1'b0;
      end else begin
         if (ir_en && bit_start && !tx_bit) begin
            pulse_cnt <= ir_fast ? `ULM_IR11_TICKS : `ULM_IR10_TICKS;
            ir_tx <= 1'b1;
         end else if (tick16 && pulse_cnt != 4'h0) begin
            pulse_cnt <= pulse_cnt - 4'h1;
            ir_tx <= (pulse_cnt != 4'h1);
         end else if (!ir_en) begin
            ir_tx <= 1'b0;
         end
      end
   end

   // decoder: a light pulse stretches to one low bit; line idles low
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_line_d <= 1'b0;
         hold_cnt <= 5'h00;
         rx_bit <= 1'b1;
      end else begin
         rx_line_d <= rx_line;
         if (ir_en && rx_line && !rx_line_d) begin
            hold_cnt <= `ULM_TICKS_PER_BIT;
            rx_bit <= 1'b0;
         end else if (tick16 && hold_cnt != 5'h00) begin
            hold_cnt <= hold_cnt - 5'h01;
            rx_bit <= (hold_cnt == 5'h01);
         end
      end
   end

endmodule

`default_nettype wire

/* File: verilog/ulm_line_modes.v */
`timescale 1ns/1ps
`default_nettype none
`include "ulm_consts.vh"

module ulm_line_modes (
   // clock and reset
   input wire clk,
   input wire nrst,
   // configuration register images
   input wire [7:0] setup_hysteresis_reg,
   input wire [7:0] special_function_reg,
   input wire [7:0] enhanced_feature_reg,
   input wire [7:0] line_control_reg,
   input wire [7:0] modem_control_reg,
   input wire [7:0] irq_enable_reg,
   input wire [7:0] fifo_control_reg,
   input wire [7:0] match_char_two,
   input wire rs485_en,
   // software strobes
   input wire sfr_addr_wr,
   input wire thr_wr,
   input wire rx_en_set,
   input wire rx_en_clr,
   // transmit core side
   input wire tick16,
   input wire bit_start,
   input wire tx_pending,
   input wire tx_shift_busy,
   input wire tx_shift_bit,
   input wire rts_req,
   input wire dtr_req,
   output wire tx_go,
   output wire tx_push_ninth,
   // receive core side
   input wire rx_char_valid,
   input wire [7:0] rx_char,
   input wire rx_ninth,
   input wire rx_shift_busy,
   output wire rx_serial,
   output reg rx_fifo_push,
   output reg [7:0] rx_fifo_data,
   output reg rx_fifo_perr,
   output reg lsr_irq,
   output wire rx_on_status,
   output wire mdrop_cfg_ok,
   // sleep inputs from the core
   input wire irq_pending,
   input wire [3:0] modem_status_reg,
   input wire divisor_nonzero,
   input wire tx_fifo_empty,
   input wire rx_fifo_empty,
   // sleep outputs
   output reg asleep,
   output wire osc_output_pin_en,
   output reg wake_irq,
   // modem inputs seen by the core
   output wire cts_core_n,
   output wire dsr_core_n,
   output wire cd_core_n,
   output wire ri_core_n,
   // pins
   input wire rx_pin,
   input wire cts_pin_n,
   input wire dsr_pin_n,
   input wire cd_pin_n,
   input wire ri_pin_n,
   input wire sleep_pin,
   output reg tx_pin,
   output reg rts_pin_n,
   output reg dtr_pin_n
);

   localparam [3:0] S_IDLE = 4'b0001;
   localparam [3:0] S_SETUP = 4'b0010;
   localparam [3:0] S_SEND = 4'b0100;
   localparam [3:0] S_TURN = 4'b1000;

   // pin synchronisers: first stage feeds only the second
   reg [6:0] sync_a;
   reg [6:0] sync_b;
   wire rx_s = sync_b[0];
   wire [3:0] modem_s = sync_b[4:1];
   wire sleep_s = sync_b[5];

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync_a <= 7'h1e;
         sync_b <= 7'h1e;
      end else begin
         sync_a <= {1'b0, sleep_pin, ri_pin_n, cd_pin_n, dsr_pin_n, cts_pin_n, rx_pin};
         sync_b <= sync_a;
      end
   end

   // mode decode
   wire enh = enhanced_feature_reg[`ULM_EFR_ENH];
   wire mdrop = special_function_reg[`ULM_SFR_MDROP] & enh;
   wire md_norm = mdrop & ~enhanced_feature_reg[`ULM_EFR_SPCHAR];
   wire md_auto = mdrop & enhanced_feature_reg[`ULM_EFR_SPCHAR];
   wire ir_en = modem_control_reg[`ULM_MCR_IRDA];
   wire ir_fast = special_function_reg[`ULM_SFR_IRDA11] & enh;
   wire loop = modem_control_reg[`ULM_MCR_LOOP];
   wire [3:0] setup_bits = setup_hysteresis_reg[`ULM_SHR_SETUP_HI:`ULM_SHR_SETUP_LO];
   wire [3:0] turn_bits = setup_hysteresis_reg[`ULM_SHR_TURN_HI:`ULM_SHR_TURN_LO];

   // multidrop needs this side's line control to force parity 0; exposed so software can be checked
   assign mdrop_cfg_ok = ~mdrop |
      (line_control_reg[`ULM_LCR_PAR_HI:`ULM_LCR_PAR_LO] == `ULM_LCR_FORCE0);

   // one bit time elapses when sixteen ticks have passed
   function bit_done;
      input [3:0] tcnt;
      input tk;
      begin
         bit_done = tk & (tcnt == 4'hf);
      end
   endfunction

   // rs-485 direction timing
   reg [3:0] dir_state;
   reg [3:0] next_dir_state;
   reg [3:0] tick_cnt;
   reg [3:0] bit_cnt;
   reg load_setup;
   reg load_turn;

   always @* begin
      next_dir_state = dir_state;
      load_setup = 1'b0;
      load_turn = 1'b0;
      case (dir_state)
         S_IDLE: begin
            if (rs485_en && tx_pending) begin
               load_setup = 1'b1;
               next_dir_state = (setup_bits == 4'h0) ? S_SEND : S_SETUP;
            end
         end
         S_SETUP: begin
            if (bit_done(tick_cnt, tick16) && bit_cnt == 4'h1)
               next_dir_state = S_SEND;
         end
         S_SEND: begin
            if (!tx_pending && !tx_shift_busy) begin
               load_turn = 1'b1;
               next_dir_state = (turn_bits == 4'h0) ? S_IDLE : S_TURN;
            end
         end
         S_TURN: begin
            if (tx_pending)
               next_dir_state = S_SEND;
            else if (bit_done(tick_cnt, tick16) && bit_cnt == 4'h1)
               next_dir_state = S_IDLE;
         end
         default: next_dir_state = S_IDLE;
      endcase
      if (!rs485_en)
         next_dir_state = S_IDLE;
   end

   // shared bit-time counter for setup and turn-around
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dir_state <= S_IDLE;
         tick_cnt <= 4'h0;
         bit_cnt <= 4'h0;
      end else begin
         dir_state <= next_dir_state;
         if (load_setup || load_turn) begin
            tick_cnt <= 4'h0;
            bit_cnt <= load_setup ? setup_bits : turn_bits;
         end else if (tick16) begin
            tick_cnt <= tick_cnt + 4'h1;
            if (bit_done(tick_cnt, tick16) && bit_cnt != 4'h0)
               bit_cnt <= bit_cnt - 4'h1;
         end
      end
   end

   // data is held back until the setup delay has run
   assign tx_go = ~rs485_en | (dir_state == S_SEND);
   wire dir_active = (dir_state != S_IDLE);

   // address-byte marking for the next transmit write
   reg addr_pend;
   always @(posedge clk or negedge nrst) begin
      if (!nrst)
         addr_pend <= `ULM_RST_ADDRPEND;
      else if (sfr_addr_wr && !thr_wr)
         addr_pend <= 1'b1;
      else if (thr_wr)
         addr_pend <= 1'b0;
   end
   // a set in the same cycle as the write marks that very byte
   assign tx_push_ninth = addr_pend | sfr_addr_wr;

   // infrared codec
   wire ir_tx;
   wire ir_rx_bit;
   ulm_irda u_irda (
      .clk(clk),
      .nrst(nrst),
      .tick16(tick16),
      .bit_start(bit_start),
      .ir_en(ir_en),
      .ir_fast(ir_fast),
      .tx_bit(tx_shift_bit),
      .rx_line(rx_s),
      .ir_tx(ir_tx),
      .rx_bit(ir_rx_bit)
   );

   // receive source: loopback, infrared decode or plain pin
   assign rx_serial = loop ? tx_shift_bit : (ir_en ? ir_rx_bit : rx_s);

   // modem inputs are held inactive towards the core in loopback
   assign cts_core_n = loop | modem_s[0];
   assign dsr_core_n = loop | modem_s[1];
   assign cd_core_n = loop | modem_s[2];
   assign ri_core_n = loop | modem_s[3];

   // pin drivers, registered
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_pin <= 1'b1;
         rts_pin_n <= 1'b1;
         dtr_pin_n <= 1'b1;
      end else begin
         tx_pin <= loop ? 1'b1 : (ir_en ? ir_tx : tx_shift_bit);
         rts_pin_n <= loop ? 1'b1 : (rs485_en ? ~dir_active : ~rts_req);
         dtr_pin_n <= loop | ~dtr_req;
      end
   end

   // multidrop receive filter
   reg rx_on;
   reg acc;
   reg hw_set;
   reg hw_clr;
   reg flag_irq;
   wire match = (rx_char == match_char_two);

   always @* begin
      acc = 1'b1;
      hw_set = 1'b0;
      hw_clr = 1'b0;
      flag_irq = 1'b0;
      if (md_norm) begin
         if (rx_ninth)
            flag_irq = 1'b1;
         else if (!rx_on)
            acc = 1'b0;
      end else if (md_auto) begin
         if (rx_ninth && match) begin
            hw_set = 1'b1;
            flag_irq = 1'b1;
         end else if (rx_ninth) begin
            acc = 1'b0;
            hw_clr = 1'b1;
         end else if (!rx_on) begin
            acc = 1'b0;
         end
      end
   end

   // receiver enable: hardware set beats any clear in the same cycle
   always @(posedge clk or negedge nrst) begin
      if (!nrst)
         rx_on <= `ULM_RST_RXON;
      else if ((rx_char_valid && hw_set) || rx_en_set)
         rx_on <= 1'b1;
      else if ((rx_char_valid && hw_clr) || rx_en_clr)
         rx_on <= 1'b0;
   end
   assign rx_on_status = rx_on;

   // push towards the receive fifo, ninth bit as parity error when in multidrop
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_fifo_push <= 1'b0;
         rx_fifo_data <= 8'h00;
         rx_fifo_perr <= 1'b0;
         lsr_irq <= 1'b0;
      end else begin
         rx_fifo_push <= rx_char_valid & acc;
         lsr_irq <= rx_char_valid & acc & flag_irq;
         if (rx_char_valid && acc) begin
            rx_fifo_data <= rx_char;
            rx_fifo_perr <= rx_ninth;
         end
      end
   end

   // sleep control
   reg rx_prev;
   reg [3:0] modem_prev;
   reg pin_sleep;
   wire rx_idle = ir_en ? ~rx_s : rx_s;
   wire rx_fall = rx_prev & ~rx_s & ~loop;
   wire modem_chg = ~loop & (modem_prev != modem_s);
   wire wake_ev = rx_fall | thr_wr | modem_chg;
   wire can_sleep = irq_enable_reg[`ULM_IER_SLEEP] & ~irq_pending &
      (modem_status_reg == 4'h0) & rx_idle & divisor_nonzero &
      tx_fifo_empty & rx_fifo_empty;
   wire pin_ready = sleep_s & ~tx_shift_busy & ~rx_shift_busy;

   // edge history for wake detection
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_prev <= 1'b0; // matches the rx synchroniser reset, no false edge
         modem_prev <= 4'hf;
      end else begin
         rx_prev <= rx_s;
         modem_prev <= modem_s;
      end
   end

   // the pin holds sleep until released; software sleep re-enters by itself
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         asleep <= 1'b0;
         pin_sleep <= 1'b0;
         wake_irq <= 1'b0;
      end else begin
         wake_irq <= 1'b0;
         if (pin_sleep) begin
            if (!sleep_s) begin
               asleep <= 1'b0;
               pin_sleep <= 1'b0;
               wake_irq <= fifo_control_reg[`ULM_FCR_WAKE];
            end
         end else if (pin_ready) begin
            asleep <= 1'b1;
            pin_sleep <= 1'b1;
         end else if (asleep) begin
            if (wake_ev || !irq_enable_reg[`ULM_IER_SLEEP]) begin
               asleep <= 1'b0;
               wake_irq <= wake_ev & fifo_control_reg[`ULM_FCR_WAKE];
            end
         end else if (can_sleep && !wake_ev) begin
            asleep <= 1'b1;
         end
      end
   end

   // oscillator output runs only while awake
   assign osc_output_pin_en = ~asleep;

endmodule

`default_nettype wire

/* File: sim/ulm_line_modes_props.sv */
`timescale 1ns/1ps
`default_nettype none
module ulm_line_modes_props (
   // clock and reset
   input wire clk,
   input wire nrst,
   // configuration
   input wire [7:0] special_function_reg,
   input wire [7:0] enhanced_feature_reg,
   input wire [7:0] modem_control_reg,
   input wire [7:0] match_char_two,
   input wire sfr_addr_wr,
   // receive side
   input wire rx_char_valid,
   input wire [7:0] rx_char,
   input wire rx_ninth,
   input wire rx_fifo_push,
   input wire rx_fifo_perr,
   input wire lsr_irq,
   input wire rx_on_status,
   // watched outputs
   input wire tx_push_ninth,
   input wire asleep,
   input wire osc_output_pin_en,
   input wire tx_pin,
   input wire cts_core_n,
   input wire ri_core_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // byte arrival per multidrop flavour
   wire md = special_function_reg[6] & enhanced_feature_reg[4] & rx_char_valid;
   wire nm = md & !enhanced_feature_reg[5];
   wire am = md & enhanced_feature_reg[5];
   wire hit = rx_ninth && (rx_char == match_char_two);
   property p_osc; osc_output_pin_en != asleep; endproperty
   a_osc: assert property (p_osc) else $error("clock out while asleep");
   property p_loop; modem_control_reg[4] && $past(modem_control_reg[4]) |-> tx_pin && cts_core_n && ri_core_n;
   endproperty
   a_loop: assert property (p_loop) else $error("loopback pins wrong");
   property p_drop; nm && !rx_ninth && !rx_on_status |=> !rx_fifo_push; endproperty
   a_drop: assert property (p_drop) else $error("data byte kept");
   property p_addr; nm && rx_ninth |=> rx_fifo_push && rx_fifo_perr && lsr_irq; endproperty
   a_addr: assert property (p_addr) else $error("address byte lost");
   property p_skip; am && !rx_on_status && !hit |=> !rx_fifo_push; endproperty
   a_skip: assert property (p_skip) else $error("unaddressed byte kept");
   property p_hit; am && hit |=> rx_fifo_push && rx_fifo_perr && lsr_irq && rx_on_status; endproperty
   a_hit: assert property (p_hit) else $error("match not taken");
   property p_miss; am && rx_ninth && !hit |=> !rx_fifo_push && !rx_on_status; endproperty
   a_miss: assert property (p_miss) else $error("foreign address kept");
   property p_ninth; sfr_addr_wr |-> tx_push_ninth; endproperty
   a_ninth: assert property (p_ninth) else $error("ninth bit not marked");
   // main scenarios reached
   c_addr: cover property (nm && rx_ninth);
   c_hit: cover property (am && hit);
   c_nap: cover property ($rose(asleep));
endmodule
bind ulm_line_modes ulm_line_modes_props i_ulm_line_modes_props (.clk, .nrst, .special_function_reg,
   .enhanced_feature_reg, .modem_control_reg, .match_char_two, .sfr_addr_wr, .rx_char_valid, .rx_char,
   .rx_ninth, .rx_fifo_push, .rx_fifo_perr, .lsr_irq, .rx_on_status, .tx_push_ninth, .asleep,
   .osc_output_pin_en, .tx_pin, .cts_core_n, .ri_core_n);
`default_nettype wire

/* File: sim/ulm_line_xcvr.sv */
`timescale 1ns/1ps
`default_nettype none
module ulm_line_xcvr (
   // clock
   input wire clk,
   // line control
   input wire kick,
   input wire idle_lvl,
   output logic rx_pin
);
   logic [2:0] cnt = 3'h0;
   // start bit or light pulse lasts four clocks
   always @(posedge clk) begin
      if (kick) begin
         cnt <= 3'h4;
      end else if (cnt != 3'h0) begin
         cnt <= cnt - 3'h1;
      end
   end
   // released line rests at its pull level, never at a stale value
   assign rx_pin = (cnt != 3'h0) ? ~idle_lvl : idle_lvl;
endmodule
`default_nettype wire

/* File: sim/ulm_line_modes_test.sv */
`timescale 1ns/1ps
`default_nettype none
module ulm_line_modes_test;
   logic clk, nrst, rs485_en, sfr_addr_wr, thr_wr, rx_en_set, rx_en_clr, tick16, bit_start, tx_pending;
   logic tx_shift_busy, tx_shift_bit, rts_req, dtr_req, rx_char_valid, rx_ninth, rx_shift_busy, irq_pending;
   logic divisor_nonzero, tx_fifo_empty, rx_fifo_empty, cts_pin_n, dsr_pin_n, cd_pin_n, ri_pin_n, sleep_pin;
   logic [7:0] setup_hysteresis_reg, special_function_reg, enhanced_feature_reg, line_control_reg;
   logic [7:0] modem_control_reg, irq_enable_reg, fifo_control_reg, match_char_two, rx_char;
   logic [3:0] modem_status_reg;
   logic kick, idle_lvl, woke;
   wire rx_pin, tx_go, tx_push_ninth, rx_serial, rx_fifo_push, rx_fifo_perr, lsr_irq, rx_on_status;
   wire mdrop_cfg_ok, asleep, osc_output_pin_en, wake_irq, tx_pin, rts_pin_n, dtr_pin_n;
   wire cts_core_n, dsr_core_n, cd_core_n, ri_core_n;
   wire [7:0] rx_fifo_data;
   int failures = 0, n_compared = 0, n, i;

   ulm_line_modes i_ulm_line_modes (.*);
   ulm_line_xcvr i_ulm_line_xcvr (.clk(clk), .kick(kick), .idle_lvl(idle_lvl), .rx_pin(rx_pin));

   // 100 MHz clock
   always #5 clk = ~clk;

   task step(input int k);
      repeat (k) begin
         @(posedge clk);
         #1;
         woke |= wake_irq;
      end
   endtask

   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   // one received character from the core, answer lands one cycle later
   task rx(input logic [7:0] c, input logic nb);
      rx_char = c;
      rx_ninth = nb;
      rx_char_valid = 1;
      step(1);
      rx_char_valid = 0;
   endtask

   task nap(input logic lvl);
      for (n = 0; n < 20 && asleep !== lvl; n++) step(1);
      chk("asleep", lvl, asleep);
   endtask

   task t_normal;
      special_function_reg = 8'h40;
      rx(8'h12, 0);
      chk("plain", 16'h0412, {rx_fifo_push, rx_fifo_perr, lsr_irq, rx_fifo_data});
      enhanced_feature_reg = 8'h10;
      #1 chk("cfg_bad", 0, mdrop_cfg_ok);
      line_control_reg = 8'h38;
      #1 chk("cfg_ok", 1, mdrop_cfg_ok);
      rx(8'h12, 0);
      chk("drop", 0, rx_fifo_push);
      rx(8'ha5, 1);
      chk("adr", 16'h07a5, {rx_fifo_push, rx_fifo_perr, lsr_irq, rx_fifo_data});
      rx_en_set = 1;
      step(1);
      rx_en_set = 0;
      rx(8'h3c, 0);
      chk("data", 16'h043c, {rx_fifo_push, rx_fifo_perr, lsr_irq, rx_fifo_data});
      rx(8'h99, 1);
      chk("adr2", 16'h0799, {rx_fifo_push, rx_fifo_perr, lsr_irq, rx_fifo_data});
      rx_en_clr = 1;
      step(1);
      rx_en_clr = 0;
   endtask

   task t_auto;
      enhanced_feature_reg = 8'h30;
      match_char_two = 8'h5a;
      rx(8'h5a, 0);
      chk("a_data", 0, rx_fifo_push);
      rx(8'h11, 1);
      chk("a_miss", 0, {rx_on_status, rx_fifo_push});
      rx(8'h5a, 1);
      chk("a_hit", 16'h0f5a, {rx_on_status, rx_fifo_push, rx_fifo_perr, lsr_irq, rx_fifo_data});
      rx(8'h22, 0);
      chk("a_next", 16'h0c22, {rx_on_status, rx_fifo_push, rx_fifo_perr, lsr_irq, rx_fifo_data});
      rx(8'h5a, 1);
      chk("a_again", 16'h0f5a, {rx_on_status, rx_fifo_push, rx_fifo_perr, lsr_irq, rx_fifo_data});
      rx(8'h33, 1);
      chk("a_off", 0, {rx_on_status, rx_fifo_push});
      {special_function_reg, enhanced_feature_reg} = 16'h0000;
   endtask

   task t_ninth;
      sfr_addr_wr = 1;
      #1 chk("mark", 1, tx_push_ninth);
      step(1);
      sfr_addr_wr = 0;
      #1 chk("held", 1, tx_push_ninth);
      thr_wr = 1;
      step(1);
      thr_wr = 0;
      #1 chk("self_clr", 0, tx_push_ninth);
   endtask

   // setup two bit times, turn-around one, 16 clocks per bit
   task t_rs485;
      setup_hysteresis_reg = 8'h21;
      rs485_en = 1;
      tx_pending = 1;
      for (n = 0; n < 9 && rts_pin_n; n++) step(1);
      chk("go_early", 0, {rts_pin_n, tx_go});
      for (n = 0; n < 99 && !tx_go; n++) step(1);
      chk("setup", 1, n >= 29 && n <= 33);
      tx_shift_busy = 1;
      step(4);
      tx_pending = 0;
      step(4);
      tx_shift_busy = 0;
      for (n = 0; n < 99 && !rts_pin_n; n++) step(1);
      chk("turn", 1, n >= 15 && n <= 20);
      rs485_en = 0;
   endtask

   task t_irda;
      modem_control_reg = 8'h40;
      enhanced_feature_reg = 8'h10;
      idle_lvl = 0;
      tx_shift_bit = 0;
      for (i = 0; i < 2; i++) begin
         special_function_reg = i ? 8'h08 : 8'h00;
         step(20);
         bit_start = 1;
         step(1);
         bit_start = 0;
         n = 0;
         repeat (16) begin
            n += tx_pin;
            step(1);
         end
         chk("ir_pulse", 3 + i, n);
      end
      kick = 1;
      step(1);
      kick = 0;
      step(4);
      chk("ir_rx", 0, rx_serial);
      step(24);
      chk("ir_idle", 1, rx_serial);
      {modem_control_reg, special_function_reg, enhanced_feature_reg} = 24'h0000_00;
      idle_lvl = 1;
      step(4);
      chk("ir_off", 0, tx_pin);
      tx_shift_bit = 1;
   endtask

   task t_loop;
      modem_control_reg = 8'h10;
      {rts_req, dtr_req, tx_shift_bit} = 3'h6;
      {cts_pin_n, dsr_pin_n, cd_pin_n, ri_pin_n} = 4'h0;
      step(4);
      chk("loop", 16'h00fe, {tx_pin, rts_pin_n, dtr_pin_n, cts_core_n, dsr_core_n, cd_core_n, ri_core_n, rx_serial});
      modem_control_reg = 8'h00;
      step(4);
      chk("normal", 0, {tx_pin, rts_pin_n, dtr_pin_n, cts_core_n, dsr_core_n, cd_core_n, ri_core_n});
      {rts_req, dtr_req, tx_shift_bit} = 3'h1;
      {cts_pin_n, dsr_pin_n, cd_pin_n, ri_pin_n} = 4'hf;
      step(4);
   endtask

   task t_sleep;
      irq_enable_reg = 8'h10;
      for (i = 0; i < 4; i++) begin
         {divisor_nonzero, tx_fifo_empty, rx_fifo_empty, modem_status_reg[0]} = 4'he ^ (4'h1 << i);
         step(8);
         chk("blocked", 0, asleep);
      end
      {divisor_nonzero, tx_fifo_empty, rx_fifo_empty, modem_status_reg[0]} = 4'he;
      nap(1);
      chk("osc", 0, osc_output_pin_en);
      {kick, irq_pending} = 2'h3;
      step(1);
      kick = 0;
      nap(0);
      step(8);
      chk("awake", 0, {asleep, woke});
      irq_pending = 0;
      nap(1);
      fifo_control_reg = 8'h08;
      {thr_wr, irq_pending} = 2'h3;
      step(1);
      thr_wr = 0;
      nap(0);
      chk("wake_irq", 1, woke);
      irq_pending = 0;
      nap(1);
      {cts_pin_n, irq_pending} = 2'h1;
      nap(0);
      {cts_pin_n, irq_pending} = 2'h2;
      nap(1);
      irq_enable_reg = 8'h00;
      nap(0);
      {tx_shift_busy, rx_shift_busy, sleep_pin} = 3'h7;
      step(8);
      chk("pin_busy", 0, asleep);
      {tx_shift_busy, rx_shift_busy} = 2'h0;
      nap(1);
      thr_wr = 1;
      step(1);
      thr_wr = 0;
      step(8);
      chk("pin_hold", 1, asleep);
      sleep_pin = 0;
      nap(0);
   endtask

   task close_out;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // stimulus; inputs settle at rest values before reset ends
   initial begin
      {setup_hysteresis_reg, special_function_reg, enhanced_feature_reg, line_control_reg} = '0;
      {modem_control_reg, irq_enable_reg, fifo_control_reg, match_char_two, rx_char, modem_status_reg} = '0;
      {rs485_en, sfr_addr_wr, thr_wr, rx_en_set, rx_en_clr, bit_start, tx_pending, tx_shift_busy} = '0;
      {rts_req, dtr_req, rx_char_valid, rx_ninth, rx_shift_busy, irq_pending, sleep_pin, kick} = '0;
      {nrst, clk, woke} = '0;
      {tick16, tx_shift_bit, divisor_nonzero, tx_fifo_empty, rx_fifo_empty, idle_lvl} = '1;
      {cts_pin_n, dsr_pin_n, cd_pin_n, ri_pin_n} = '1;
      repeat (12) @(posedge clk);
      #1 nrst = 1;
      step(3);
      chk("reset", 16'h0007, {asleep, rx_on_status, wake_irq, tx_pin, rts_pin_n, dtr_pin_n});
      t_normal;
      t_auto;
      t_ninth;
      t_rs485;
      t_irda;
      t_loop;
      t_sleep;
      close_out;
   end

   // hang guard at 10000 cycles, well past the few hundred cycles the run needs
   initial begin
      #100000;
      failures++;
      close_out;
   end
endmodule
`default_nettype wire
